// ===== rtl/calu_defs.svh
// constants of the core datapath: widths, register indexes, flag bits, counts
`ifndef CALU_DEFS_SVH
`define CALU_DEFS_SVH
// ==========================================
// widths
`define CALU_AW        4
`define CALU_DW        16
`define CALU_MAW       9
`define CALU_MEM_WORDS 512
`define CALU_PAW       10
`define CALU_LAST_PAGE 2'h3
// ==========================================
// register indexes on the software port
`define CALU_REG_CMD   4'h0
`define CALU_REG_OPND  4'h1
`define CALU_REG_IMM   4'h2
`define CALU_REG_ACC   4'h3
`define CALU_REG_FLAGS 4'h4
`define CALU_REG_TABLE_POINTER_LOW  4'h5
`define CALU_REG_TABLE_POINTER_HIGH  4'h6
`define CALU_REG_TABLE_HIGH_BYTE_LATCH  4'h7
`define CALU_REG_BANK  4'h8
`define CALU_REG_MADDR 4'h9
`define CALU_REG_MDATA 4'ha
`define CALU_REG_STAT  4'hb
// ==========================================
// flag bit positions
`define CALU_F_C       0
`define CALU_F_AC      1
`define CALU_F_Z       2
`define CALU_F_OV      3
`define CALU_F_SC      4
`define CALU_F_CZ      5
`define CALU_FLAGS_W   6
// ==========================================
// reset values and arithmetic constants
`define CALU_RST_BYTE  8'h00
`define CALU_RST_FLAGS 6'h00
`define CALU_BCD_LIMIT 4'h9
`define CALU_BCD_LOW   8'h06
`define CALU_BCD_HIGH  8'h60
`define CALU_ONE       8'h01
`define CALU_DUMMY_BAS 2'h1
`define CALU_DUMMY_EXT 2'h2
`endif

// ===== rtl/calu_pkg.sv
// types of the core datapath: instruction codes and sequencer states
`default_nettype none
package calu_pkg;
	// ==========================================
	// instruction codes, in order from 5'h00
	typedef enum logic [4:0] {
		OP_SUB_ACC, OP_SUB_IMM, OP_SUBTRACT_TO_MEMORY,
		OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_TO_ACC,
		OP_SKIP_IF_ZERO, OP_SKIP_IF_ZERO_COPY, OP_SKIP_IF_ZERO_BIT,
		OP_TABLE_READ_PAGED, OP_TABLE_READ_LAST_PAGE,
		OP_TABLE_READ_PAGED_PREINC, OP_TABLE_READ_LAST_PREINC,
		OP_XOR_ACC, OP_XOR_TO_MEMORY, OP_XOR_IMM,
		OP_EXT_ADD_CARRY_ACC, OP_EXT_ADD_CARRY_MEM, OP_EXT_SUM_ACC, OP_EXT_SUM_MEM,
		OP_EXT_BITWISE_CONJ, OP_EXT_BITWISE_CONJ_MEM, OP_EXT_ZERO_MEM, OP_EXT_ZERO_BIT,
		OP_EXT_INVERT_MEM, OP_EXT_INVERT_TO_ACC, OP_EXT_BCD_ADJUST_TO_MEM,
		OP_EXT_MEM_DECREMENT, OP_EXT_SKIP_IF_ZERO
	} calu_op_type;
	// ==========================================
	// sequencer states
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_EXEC   = 4'b0010,
		ST_TFETCH = 4'b0100,
		ST_DUMMY  = 4'b1000
	} calu_state_type;
endpackage
`default_nettype wire

// ===== rtl/calu_addsub.sv
// eight-bit adder and subtractor with carry, half carry and overflow
`timescale 1ns/1ps
`default_nettype none
module calu_addsub (
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       sub,
	input  wire logic       cin,
	output logic      [7:0] sum,
	output logic            c_out,
	output logic            ac_out,
	output logic            ov_out
);
	// ==========================================
	// two nibble adders; subtract is a plus inverted b plus carry in
	wire logic [7:0] bx = sub ? ~b : b;                    // operand as added
	wire logic [4:0] lo = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
	wire logic [4:0] hi = {1'b0, a[7:4]} + {1'b0, bx[7:4]} + {4'h0, lo[4]};
	assign sum    = {hi[3:0], lo[3:0]};
	assign c_out  = hi[4];                                 // high means no borrow
	assign ac_out = lo[4];
	assign ov_out = (a[7] == bx[7]) && (sum[7] != a[7]);
endmodule
`default_nettype wire

// ===== rtl/calu_bcd.sv
// decimal adjust of the accumulator after a bcd addition
`timescale 1ns/1ps
`include "calu_defs.svh"
`default_nettype none
module calu_bcd (
	input  wire logic [7:0] acc,
	input  wire logic       ac_in,
	input  wire logic       c_in,
	output logic      [7:0] res,
	output logic            c_out
);
	// ==========================================
	// nibble tests and the adjusting sum
	wire logic       lo_adj = (acc[3:0] > `CALU_BCD_LIMIT) || ac_in;   // low nibble
	wire logic       hi_adj = (acc[7:4] > `CALU_BCD_LIMIT) || c_in;    // high nibble
	wire logic [7:0] add_lo = lo_adj ? `CALU_BCD_LOW : 8'h00;
	wire logic [7:0] add_hi = hi_adj ? `CALU_BCD_HIGH : 8'h00;
	wire logic [8:0] sum    = {1'b0, acc} + {1'b0, add_lo} + {1'b0, add_hi};
	assign res   = sum[7:0];
	assign c_out = c_in || hi_adj || sum[8];                // decimal sum passed 99
endmodule
`default_nettype wire

// ===== rtl/calu_top.sv
// execution datapath of the 8-bit core: accumulator, flags, data memory, table reads
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "calu_defs.svh"
`default_nettype none
module calu_top (
	input  wire logic               SYS_CLK,
	input  wire logic               ARST_N,
	input  wire logic [`CALU_AW-1:0] ADDR,
	input  wire logic [`CALU_DW-1:0] WR_DATA,
	input  wire logic               WR_STB,
	input  wire logic               RD_STB,
	output logic      [`CALU_DW-1:0] RD_DATA,
	input  wire logic [15:0]         PROG_DATA,
	output logic      [`CALU_PAW-1:0] PROG_ADDR,
	output logic                    PROG_RD,
	output logic                    BUSY,
	output logic                    SKIP,
	output logic                    DUMMY_CYCLE
);
	// ==========================================
	// state
	calu_pkg::calu_state_type state_q, state_d;            // sequencer
	calu_pkg::calu_op_type    op_q;                        // current instruction
	logic [7:0]               acc_q;                       // accumulator
	logic [`CALU_FLAGS_W-1:0] flags_q, flags_d;            // status flags
	logic [7:0]               table_pointer_low_q, table_pointer_high_q, table_high_byte_latch_q;      // table pointers, latch
	logic                     bank_q;                      // current section
	logic [`CALU_MAW-1:0]     maddr_q;                     // operand address
	logic [2:0]               bit_q;                       // operand bit index
	logic [7:0]               imm_q;                       // immediate operand
	logic [`CALU_MAW-1:0]     sw_addr_q;                   // software memory pointer
	logic [1:0]               dcnt_q;                      // dummy cycles left
	logic                     skip_q, busy_q, dummy_q;     // status outputs
	logic                     prd_q;                       // program read strobe
	logic [`CALU_PAW-1:0]     paddr_q;                     // program address
	logic [`CALU_DW-1:0]      rdata_q;                     // read answer
	logic [7:0]               mem_q [0:`CALU_MEM_WORDS-1]; // data memory

	// ==========================================
	// software port decode
	wire logic st_idle = (state_q == calu_pkg::ST_IDLE);
	wire logic st_exec = (state_q == calu_pkg::ST_EXEC);
	wire logic st_tf   = (state_q == calu_pkg::ST_TFETCH);
	wire logic wr_ok   = WR_STB && st_idle;                // writes ignored while busy
	wire logic we_cmd  = wr_ok && (ADDR == `CALU_REG_CMD);
	wire logic we_opnd = wr_ok && (ADDR == `CALU_REG_OPND);
	wire logic we_imm  = wr_ok && (ADDR == `CALU_REG_IMM);
	wire logic we_acc  = wr_ok && (ADDR == `CALU_REG_ACC);
	wire logic we_flg  = wr_ok && (ADDR == `CALU_REG_FLAGS);
	wire logic we_table_pointer_low = wr_ok && (ADDR == `CALU_REG_TABLE_POINTER_LOW);
	wire logic we_table_pointer_high = wr_ok && (ADDR == `CALU_REG_TABLE_POINTER_HIGH);
	wire logic we_bank = wr_ok && (ADDR == `CALU_REG_BANK);
	wire logic we_madr = wr_ok && (ADDR == `CALU_REG_MADDR);
	wire logic we_mdat = wr_ok && (ADDR == `CALU_REG_MDATA);

	// ==========================================
	// operand fetch
	wire logic is_ext = (op_q >= calu_pkg::OP_EXT_ADD_CARRY_ACC);
	// extended forms take the full address, basic ones the current section
	wire logic [`CALU_MAW-1:0] ea = is_ext ? maddr_q : {bank_q, maddr_q[7:0]};
	wire logic [7:0] m_rd = mem_q[ea];
	logic [7:0] bit_mask;                                   // one-hot bit select
	for (genvar gi = 0; gi < 8; gi++) begin : g_mask
		assign bit_mask[gi] = (bit_q == 3'(gi));
	end

	// ==========================================
	// arithmetic units
	logic [7:0] add_b, add_sum, bcd_res;
	logic       add_sub, add_cin, add_c, add_ac, add_ov, bcd_c;
	calu_addsub u_addsub (
		.a      (acc_q),
		.b      (add_b),
		.sub    (add_sub),
		.cin    (add_cin),
		.sum    (add_sum),
		.c_out  (add_c),
		.ac_out (add_ac),
		.ov_out (add_ov)
	);
	calu_bcd u_bcd (
		.acc   (acc_q),
		.ac_in (flags_q[`CALU_F_AC]),
		.c_in  (flags_q[`CALU_F_C]),
		.res   (bcd_res),
		.c_out (bcd_c)
	);

	// ==========================================
	// instruction decode
	logic [7:0] res;
	logic wr_acc, wr_mem, f_arith, f_cz, f_z, f_bcd, skip, ext_skip, tbl, last, pre;
	always_comb begin
		res = 8'h00;
		add_b = m_rd;
		add_sub = 1'b0;
		add_cin = 1'b0;
		{wr_acc, wr_mem, f_arith, f_cz, f_z, f_bcd} = 6'h00;
		{skip, ext_skip, tbl, last, pre} = 5'h00;
		case (op_q)
			// subtract: carry in one gives borrow convention
			calu_pkg::OP_SUB_ACC, calu_pkg::OP_SUB_IMM, calu_pkg::OP_SUBTRACT_TO_MEMORY: begin
				add_sub = 1'b1;
				add_cin = 1'b1;
				add_b = (op_q == calu_pkg::OP_SUB_IMM) ? imm_q : m_rd;
				res = add_sum;
				wr_mem = (op_q == calu_pkg::OP_SUBTRACT_TO_MEMORY);
				wr_acc = !wr_mem;
				f_arith = 1'b1;
				f_cz = 1'b1;
			end
			// nibble exchange, no flags
			calu_pkg::OP_NIBBLE_EXCHANGE, calu_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: begin
				res = {m_rd[3:0], m_rd[7:4]};
				wr_mem = (op_q == calu_pkg::OP_NIBBLE_EXCHANGE);
				wr_acc = !wr_mem;
			end
			// byte test, written back unchanged
			calu_pkg::OP_SKIP_IF_ZERO: begin
				res = m_rd;
				wr_mem = 1'b1;
				skip = (m_rd == 8'h00);
			end
			// copy to accumulator and
			calu_pkg::OP_SKIP_IF_ZERO_COPY: begin
				res = m_rd;
				wr_acc = 1'b1;
				skip = (m_rd == 8'h00);
			end
			// selected bit
			calu_pkg::OP_SKIP_IF_ZERO_BIT: begin
				skip = !(|(m_rd & bit_mask));
			end
			// table reads, finished in the fetch state
			calu_pkg::OP_TABLE_READ_PAGED: tbl = 1'b1;
			calu_pkg::OP_TABLE_READ_LAST_PAGE: {tbl, last} = 2'b11;
			calu_pkg::OP_TABLE_READ_PAGED_PREINC: {tbl, pre} = 2'b11;
			calu_pkg::OP_TABLE_READ_LAST_PREINC: {tbl, last, pre} = 3'b111;
			// exclusive or
			calu_pkg::OP_XOR_ACC, calu_pkg::OP_XOR_TO_MEMORY, calu_pkg::OP_XOR_IMM: begin
				res = acc_q ^ ((op_q == calu_pkg::OP_XOR_IMM) ? imm_q : m_rd);
				wr_mem = (op_q == calu_pkg::OP_XOR_TO_MEMORY);
				wr_acc = !wr_mem;
				f_z = 1'b1;
			end
			// additions with and without carry
			calu_pkg::OP_EXT_ADD_CARRY_ACC, calu_pkg::OP_EXT_ADD_CARRY_MEM,
			calu_pkg::OP_EXT_SUM_ACC, calu_pkg::OP_EXT_SUM_MEM: begin
				add_cin = (op_q <= calu_pkg::OP_EXT_ADD_CARRY_MEM) && flags_q[`CALU_F_C];
				res = add_sum;
				wr_mem = (op_q == calu_pkg::OP_EXT_ADD_CARRY_MEM) ||
					(op_q == calu_pkg::OP_EXT_SUM_MEM);
				wr_acc = !wr_mem;
				f_arith = 1'b1;
			end
			// bitwise and
			calu_pkg::OP_EXT_BITWISE_CONJ, calu_pkg::OP_EXT_BITWISE_CONJ_MEM: begin
				res = acc_q & m_rd;
				wr_mem = (op_q == calu_pkg::OP_EXT_BITWISE_CONJ_MEM);
				wr_acc = !wr_mem;
				f_z = 1'b1;
			end
			// clear byte or bit, no flags
			calu_pkg::OP_EXT_ZERO_MEM: wr_mem = 1'b1;
			calu_pkg::OP_EXT_ZERO_BIT: begin
				res = m_rd & ~bit_mask;
				wr_mem = 1'b1;
			end
			// ones complement
			calu_pkg::OP_EXT_INVERT_MEM, calu_pkg::OP_EXT_INVERT_TO_ACC: begin
				res = ~m_rd;
				wr_mem = (op_q == calu_pkg::OP_EXT_INVERT_MEM);
				wr_acc = !wr_mem;
				f_z = 1'b1;
			end
			// decimal adjust into memory, carry only
			calu_pkg::OP_EXT_BCD_ADJUST_TO_MEM: begin
				res = bcd_res;
				wr_mem = 1'b1;
				f_bcd = 1'b1;
			end
			// decrement in place
			calu_pkg::OP_EXT_MEM_DECREMENT: begin
				res = m_rd - `CALU_ONE;
				wr_mem = 1'b1;
				f_z = 1'b1;
			end
			// extended byte
			calu_pkg::OP_EXT_SKIP_IF_ZERO: begin
				res = m_rd;
				wr_mem = 1'b1;
				skip = (m_rd == 8'h00);
				ext_skip = 1'b1;
			end
			default: res = 8'h00;
		endcase
	end

	// ==========================================
	// flag next values; untouched flags hold
	wire logic z_new = (res == 8'h00);
	assign flags_d[`CALU_F_C]  = f_arith ? add_c : (f_bcd ? bcd_c : flags_q[`CALU_F_C]);
	assign flags_d[`CALU_F_AC] = f_arith ? add_ac : flags_q[`CALU_F_AC];
	assign flags_d[`CALU_F_Z]  = (f_arith || f_z) ? z_new : flags_q[`CALU_F_Z];
	assign flags_d[`CALU_F_OV] = f_arith ? add_ov : flags_q[`CALU_F_OV];
	assign flags_d[`CALU_F_SC] = f_arith ? (add_ov ^ add_sum[7]) : flags_q[`CALU_F_SC];
	assign flags_d[`CALU_F_CZ] = f_cz ? z_new : flags_q[`CALU_F_CZ];

	// ==========================================
	// sequencer next state
	wire logic [7:0] table_pointer_low_inc = table_pointer_low_q + `CALU_ONE;
	wire logic [7:0] table_pointer_low_use = pre ? table_pointer_low_inc : table_pointer_low_q;
	always_comb begin
		case (state_q)
			calu_pkg::ST_IDLE:   state_d = we_cmd ? calu_pkg::ST_EXEC : calu_pkg::ST_IDLE;
			calu_pkg::ST_EXEC:   state_d = tbl ? calu_pkg::ST_TFETCH :
				(skip ? calu_pkg::ST_DUMMY : calu_pkg::ST_IDLE);
			calu_pkg::ST_TFETCH: state_d = prd_q ? calu_pkg::ST_TFETCH : calu_pkg::ST_IDLE;
			calu_pkg::ST_DUMMY:  state_d = (dcnt_q == 2'h1) ? calu_pkg::ST_IDLE :
				calu_pkg::ST_DUMMY;
			default:             state_d = calu_pkg::ST_IDLE;
		endcase
	end

	// ==========================================
	// sequencer, dummy cycles and status
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_q <= calu_pkg::ST_IDLE;
			dcnt_q  <= 2'h0;
			skip_q  <= 1'b0;
			busy_q  <= 1'b0;
			dummy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			busy_q  <= (state_d != calu_pkg::ST_IDLE);
			dummy_q <= (state_d == calu_pkg::ST_DUMMY);
			if (st_exec) begin
				skip_q <= skip;
				// one dummy for basic skips, two for extended
				dcnt_q <= ext_skip ? `CALU_DUMMY_EXT : `CALU_DUMMY_BAS;
			end else if (state_q == calu_pkg::ST_DUMMY) begin
				dcnt_q <= dcnt_q - 2'h1;
			end
		end
	end

	// ==========================================
	// accumulator, flags and operand registers
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			acc_q   <= `CALU_RST_BYTE;
			flags_q <= `CALU_RST_FLAGS;
			op_q    <= calu_pkg::OP_SUB_ACC;
			{imm_q, bank_q, bit_q, maddr_q, sw_addr_q} <= '0;
		end else begin
			if (we_cmd) op_q <= calu_pkg::calu_op_type'(WR_DATA[4:0]);
			if (we_opnd) {bit_q, maddr_q} <= WR_DATA[11:0];
			if (we_imm) imm_q <= WR_DATA[7:0];
			if (we_bank) bank_q <= WR_DATA[0];
			if (we_madr) sw_addr_q <= WR_DATA[`CALU_MAW-1:0];
			if (we_acc) acc_q <= WR_DATA[7:0];
			else if (st_exec && wr_acc) acc_q <= res;
			if (we_flg) flags_q <= WR_DATA[`CALU_FLAGS_W-1:0];
			else if (st_exec) flags_q <= flags_d;
		end
	end

	// ==========================================
	// table pointers and program read
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			{table_pointer_low_q, table_pointer_high_q, table_high_byte_latch_q} <= '0;
			prd_q   <= 1'b0;
			paddr_q <= '0;
		end else begin
			prd_q <= st_exec && tbl;
			if (we_table_pointer_low) table_pointer_low_q <= WR_DATA[7:0];
			else if (st_exec && pre) table_pointer_low_q <= table_pointer_low_inc;
			if (we_table_pointer_high) table_pointer_high_q <= WR_DATA[7:0];
			if (st_exec && tbl) begin
				paddr_q <= {last ? `CALU_LAST_PAGE : table_pointer_high_q[1:0], table_pointer_low_use};
			end
			if (st_tf && !prd_q) table_high_byte_latch_q <= PROG_DATA[15:8];
		end
	end

	// ==========================================
	// data memory: execution and software writes
	always_ff @(posedge SYS_CLK) begin
		if (we_mdat) mem_q[sw_addr_q] <= WR_DATA[7:0];
		else if (st_exec && wr_mem) mem_q[ea] <= res;
		else if (st_tf && !prd_q) mem_q[ea] <= PROG_DATA[7:0];
	end

	// ==========================================
	// read answer, one cycle after the strobe
	logic [`CALU_DW-1:0] rd_mux;
	always_comb begin
		case (ADDR)
			`CALU_REG_CMD:   rd_mux = {11'h000, op_q};
			`CALU_REG_OPND:  rd_mux = {4'h0, bit_q, maddr_q};
			`CALU_REG_IMM:   rd_mux = {8'h00, imm_q};
			`CALU_REG_ACC:   rd_mux = {8'h00, acc_q};
			`CALU_REG_FLAGS: rd_mux = {10'h000, flags_q};
			`CALU_REG_TABLE_POINTER_LOW:  rd_mux = {8'h00, table_pointer_low_q};
			`CALU_REG_TABLE_POINTER_HIGH:  rd_mux = {8'h00, table_pointer_high_q};
			`CALU_REG_TABLE_HIGH_BYTE_LATCH:  rd_mux = {8'h00, table_high_byte_latch_q};
			`CALU_REG_BANK:  rd_mux = {15'h0000, bank_q};
			`CALU_REG_MADDR: rd_mux = {7'h00, sw_addr_q};
			`CALU_REG_MDATA: rd_mux = {8'h00, mem_q[sw_addr_q]};
			`CALU_REG_STAT:  rd_mux = {14'h0000, skip_q, busy_q};
			default:         rd_mux = 16'h0000;
		endcase
	end
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) rdata_q <= 16'h0000;
		else rdata_q <= RD_STB ? rd_mux : 16'h0000;
	end

	// ==========================================
	// outputs
	assign RD_DATA     = rdata_q;
	assign PROG_ADDR   = paddr_q;
	assign PROG_RD     = prd_q;
	assign BUSY        = busy_q;
	assign SKIP        = skip_q;
	assign DUMMY_CYCLE = dummy_q;

	// ==========================================
	// checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	a_sub_carry_sense: assert property (
		(st_exec && add_sub) |=> (flags_q[`CALU_F_C] == ($past(acc_q) >= $past(add_b))))
		else $error("subtract carry does not match borrow");
	a_nibble_flags_kept: assert property (
		(st_exec && (op_q == calu_pkg::OP_NIBBLE_EXCHANGE_TO_ACC))
		|=> $stable(flags_q) && (acc_q == {$past(m_rd[3:0]), $past(m_rd[7:4])}))
		else $error("nibble exchange result or flags wrong");
	a_skip_basic_len: assert property (
		(st_exec && skip && !ext_skip) |=> DUMMY_CYCLE ##1 (!DUMMY_CYCLE && !BUSY))
		else $error("basic skip dummy length wrong");
	a_skip_ext_len: assert property (
		(st_exec && skip && ext_skip) |=> DUMMY_CYCLE [*2] ##1 !DUMMY_CYCLE)
		else $error("extended skip dummy length wrong");
	a_table_last_addr: assert property (
		(st_exec && tbl && last && !pre)
		|=> PROG_RD && (PROG_ADDR == {`CALU_LAST_PAGE, $past(table_pointer_low_q)}))
		else $error("last page table address wrong");
	a_table_preinc: assert property (
		(st_exec && pre) |=> (table_pointer_low_q == $past(table_pointer_low_q) + `CALU_ONE)
		&& (PROG_ADDR[7:0] == table_pointer_low_q))
		else $error("table pointer not incremented before read");
	a_table_latch_load: assert property (
		(st_tf && !prd_q) |=> (table_high_byte_latch_q == $past(PROG_DATA[15:8])) && !BUSY)
		else $error("table high byte not latched");
	a_xor_zero_flag: assert property (
		(st_exec && (op_q == calu_pkg::OP_XOR_ACC)) |=> (acc_q == ($past(acc_q) ^ $past(m_rd)))
		&& (flags_q[`CALU_F_Z] == (acc_q == 8'h00)))
		else $error("xor result or zero flag wrong");
	a_bcd_carry_only: assert property (
		(st_exec && f_bcd) |=> (flags_q[5:1] == $past(flags_q[5:1])))
		else $error("decimal adjust touched a flag other than carry");
endmodule
`default_nettype wire

// ===== bench/calu_tb.sv
// self-checking bench of the core datapath against an integer model
`timescale 1ns/1ps
`include "calu_defs.svh"
`default_nettype none
module tb;
	// ==========================================
	// design ports and model state
	logic        SYS_CLK = 0, ARST_N = 0, WR_STB = 0, RD_STB = 0;
	logic [3:0]  ADDR = 0;
	logic [15:0] WR_DATA = 0, PROG_DATA = 0, RD_DATA;
	logic [9:0]  PROG_ADDR;
	logic        PROG_RD, BUSY, SKIP, DUMMY_CYCLE;
	int          mismatches = 0, n_checks = 0, seed = 93900, table_high_byte_latch = 0;
	int          acc, flg, mv, ea, oa, im, bi, bn, table_pointer_low, table_pointer_high, op, it, r, c, sk, cy, du, n, dn, w;

	always #4 SYS_CLK = ~SYS_CLK;

	calu_top i_calu_top (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
		.WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .PROG_DATA(PROG_DATA),
		.PROG_ADDR(PROG_ADDR), .PROG_RD(PROG_RD), .BUSY(BUSY), .SKIP(SKIP),
		.DUMMY_CYCLE(DUMMY_CYCLE));

	// program word seen at a given program address
	function automatic logic [15:0] pw(int x);
		return 16'((((~x) & 255) << 8) | ((x ^ (x >> 8)) & 255));
	endfunction

	// program memory: word only in the cycle after a request, churn otherwise
	always @(posedge SYS_CLK)
		PROG_DATA <= PROG_RD ? pw(PROG_ADDR) : 16'($random(seed));

	// ==========================================
	// compare, bus cycles, verdict
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t op=%0d seen %h exp %h", $time, op, seen, exp);
		end
	endtask
	task automatic wr(logic [3:0] ad, int d);
		@(posedge SYS_CLK);
		ADDR    <= ad;
		WR_DATA <= 16'(d);
		WR_STB  <= 1'b1;
		@(posedge SYS_CLK);
		WR_STB  <= 1'b0;
	endtask
	task automatic rc(logic [3:0] ad, int e);
		@(posedge SYS_CLK);
		ADDR   <= ad;
		RD_STB <= 1'b1;
		@(posedge SYS_CLK);
		RD_STB <= 1'b0;
		// read data stand only in this cycle; look once they have settled
		#1;
		chk(RD_DATA, 16'(e));
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================
	// model: add or subtract with full flag update, cz kept
	task automatic arith(int x, int y, int ci, int sub);
		int s, h, ov, z;
		s = sub ? x - y : x + y + ci;
		h = sub ? (x & 15) >= (y & 15) : (x & 15) + (y & 15) + ci > 15;
		r = s & 255;
		z = r == 0;
		ov = sub ? ((x ^ y) & (x ^ r) & 128) != 0 : (~(x ^ y) & (x ^ r) & 128) != 0;
		c = sub ? s >= 0 : s > 255;
		flg = (flg & 'h20) | c | (h << 1) | (z << 2) | (ov << 3) | ((ov ^ (r >> 7)) << 4);
	endtask
	task automatic zf(int x);
		flg = (flg & 'h3b) | (int'(x == 0) << 2);
	endtask
	task automatic model;
		int lo, hi, s;
		c = flg & 1;
		sk = 0;
		cy = 1;
		case (op)
			0, 1, 2: begin
				arith(acc, op == 1 ? im : mv, 0, 1);
				flg = (flg & 'h1f) | (int'(r == 0) << 5);
				if (op == 2) mv = r;
				else acc = r;
			end
			3: mv = ((mv & 15) << 4) | (mv >> 4);
			4: acc = ((mv & 15) << 4) | (mv >> 4);
			5, 27: sk = mv == 0;
			6: begin
				acc = mv;
				sk = mv == 0;
			end
			7: sk = ((mv >> bi) & 1) == 0;
			8, 9, 10, 11: begin
				if (op >= 10) table_pointer_low = (table_pointer_low + 1) & 255;
				w = pw((op & 1) ? ({`CALU_LAST_PAGE, 8'h00} | table_pointer_low) : table_pointer_high * 256 + table_pointer_low);
				mv = w & 255;
				table_high_byte_latch = w >> 8;
				cy = 3;
			end
			12: acc = acc ^ mv;
			13: mv = acc ^ mv;
			14: acc = acc ^ im;
			15, 16, 17, 18: begin
				arith(acc, mv, op < 17 ? c : 0, 0);
				if (op & 1) acc = r;
				else mv = r;
			end
			19: acc = acc & mv;
			20: mv = acc & mv;
			21: mv = 0;
			22: mv = mv & ~(1 << bi);
			23: mv = ~mv & 255;
			24: acc = ~mv & 255;
			25: begin
				lo = (acc & 15) > 9 || (flg & 2);
				hi = (acc >> 4) > 9 || c;
				s = acc + (lo ? 6 : 0) + (hi ? 96 : 0);
				mv = s & 255;
				flg = (flg & 'h3e) | (c | hi | (s > 255));
			end
			26: mv = (mv - 1) & 255;
			default: ;
		endcase
		if (op >= 12 && op <= 24 && op != 15 && op != 16 && op != 17 && op != 18 && op < 21
			|| op == 23 || op == 24 || op == 26)
			zf(op == 13 || op == 20 || op == 23 || op == 26 ? mv : acc);
		if (sk) cy = op == 27 ? 3 : 2;
		// every cycle past the execute cycle is a dummy, except for table fetches
		du = (op >= 8 && op <= 11) ? 0 : cy - 1;
	endtask

	// ==========================================
	// main sequence
	initial begin
		repeat (10) @(posedge SYS_CLK);
		ARST_N <= 1'b1;
		rc(`CALU_REG_FLAGS, 0);
		rc(`CALU_REG_TABLE_HIGH_BYTE_LATCH, 0);
		for (it = 0; it < 6; it++) begin
			for (op = 0; op < 32; op++) begin
				mv = it == 0 ? 0 : $random(seed) & 255;
				acc = it == 1 ? mv : $random(seed) & 255;
				im = it == 2 ? acc : $random(seed) & 255;
				flg = $random(seed) & 63;
				bn = $random(seed) & 1;
				oa = $random(seed) & 511;
				bi = $random(seed) & 7;
				table_pointer_low = $random(seed) & 255;
				table_pointer_high = $random(seed) & 3;
				ea = op < 15 ? bn * 256 + (oa & 255) : oa;
				wr(`CALU_REG_BANK, bn);
				wr(`CALU_REG_ACC, acc);
				wr(`CALU_REG_FLAGS, flg);
				wr(`CALU_REG_TABLE_POINTER_LOW, table_pointer_low);
				wr(`CALU_REG_TABLE_POINTER_HIGH, table_pointer_high);
				wr(`CALU_REG_IMM, im);
				wr(`CALU_REG_OPND, (bi << 9) | oa);
				wr(`CALU_REG_MADDR, ea);
				wr(`CALU_REG_MDATA, mv);
				model;
				wr(`CALU_REG_CMD, op);
				#1;
				n = 0;
				dn = 0;
				// count busy and dummy cycles, bounded
				while (BUSY === 1'b1 && n < 20) begin
					@(posedge SYS_CLK);
					#1;
					n++;
					dn += int'(DUMMY_CYCLE === 1'b1);
				end
				chk(16'(n), 16'(cy));
				chk(16'(dn), 16'(du));
				chk(16'(SKIP), 16'(sk));
				rc(`CALU_REG_ACC, acc);
				rc(`CALU_REG_FLAGS, flg);
				rc(`CALU_REG_MDATA, mv);
				rc(`CALU_REG_TABLE_HIGH_BYTE_LATCH, table_high_byte_latch);
				rc(`CALU_REG_TABLE_POINTER_LOW, table_pointer_low);
			end
			$display("pass %0d done", it);
		end
		// write while busy is dropped, unmapped index reads zero
		op = 8;
		wr(`CALU_REG_CMD, op);
		wr(`CALU_REG_ACC, ~acc & 255);
		repeat (3) @(posedge SYS_CLK);
		rc(`CALU_REG_ACC, acc);
		rc(4'hf, 0);
		$display("refusal test done");
		results;
	end

	// watchdog: about four times the expected run of some 6200 cycles
	initial begin
		#200000;
		mismatches++;
		results;
	end
endmodule
`default_nettype wire
